// ---- common/smp_pkg.sv ----
// Purpose: shared constants, states and carriers of the message parser
// Assumes: byte-wide ASCII stream from the bus acceptor layer
// Notes:   character codes are ASCII byte values
package smp_pkg;
	// ----------------------------------------
	// character codes
	// ----------------------------------------
	localparam logic [7:0] CH_LF    = 8'h0A;
	localparam logic [7:0] CH_SP    = 8'h20;
	localparam logic [7:0] CH_COLON = 8'h3A;
	localparam logic [7:0] CH_SEMI  = 8'h3B;
	localparam logic [7:0] CH_COMMA = 8'h2C;
	localparam logic [7:0] CH_STAR  = 8'h2A;
	localparam logic [7:0] CH_DOT   = 8'h2E;
	localparam logic [7:0] CH_PLUS  = 8'h2B;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_E     = 8'h45;
	localparam logic [7:0] CH_K     = 8'h4B;
	localparam logic [7:0] CH_M     = 8'h4D;
	localparam logic [7:0] CH_G     = 8'h47;
	localparam logic [7:0] CH_3     = 8'h33;
	localparam logic [7:0] CH_6     = 8'h36;
	localparam logic [7:0] CH_9     = 8'h39;
	localparam logic [7:0] CASE_GAP = 8'h20;
	// ----------------------------------------
	// limits and reset values
	// ----------------------------------------
	localparam logic [8:0] MSG_MAX   = 9'h100;
	localparam logic [8:0] OUT_MAX   = 9'h100;
	localparam logic [4:0] ADDR_RST  = 5'h06;
	localparam logic [2:0] DEPTH_MAX = 3'h7;
	localparam logic [2:0] Q_DEPTH   = 3'h4;
	// ----------------------------------------
	// states and kinds
	// ----------------------------------------
	typedef enum logic [2:0] {P_START = 3'b000, P_NODE = 3'b001, P_MNEM = 3'b010,
		P_PARAM = 3'b011, P_SKIP = 3'b100} smp_pst_t;
	typedef enum logic [3:0] {N_NONE = 4'b0000, N_SIGN = 4'b0001, N_INT = 4'b0010, N_FRAC = 4'b0011,
		N_EXPE = 4'b0100, N_EXPS = 4'b0101, N_EXPD = 4'b0110, N_SUFX = 4'b0111,
		N_WORD = 4'b1000, N_BAD = 4'b1001} smp_nst_t;
	typedef enum logic [2:0] {K_MNEM = 3'b000, K_PARAM = 3'b001, K_ROOT = 3'b010, K_DOWN = 3'b011,
		K_PSEP = 3'b100, K_CEND = 3'b101, K_MEND = 3'b110} smp_kind_t;
	typedef enum logic [1:0] {R_CHAR = 2'b00, R_ITEM = 2'b01, R_UNIT = 2'b10, R_END = 2'b11} smp_rkind_t;
	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {logic valid; logic [7:0] chr; logic eoi; logic get;} smp_rx_t;
	typedef struct packed {logic valid; smp_kind_t kind; logic [7:0] chr; logic last; logic common;} smp_tok_t;
	typedef struct packed {logic valid; smp_rkind_t kind; logic [7:0] chr; logic mult;} smp_resp_t;
	typedef struct packed {logic valid; logic [7:0] chr; logic eoi;} smp_tx_t;
endpackage

// ---- design/smp_parser.sv ----
// Purpose: program message parser and response formatter
// Assumes: rx and resp come from logic on mclk; tx is taken every cycle
// Notes:   command decoding and settings live outside; they report back
`timescale 1ns/10ps
module smp_parser (
	input  wire logic           mclk,
	input  wire logic           nrst,
	input  smp_pkg::smp_rx_t    rx,
	input  wire logic           node_ok,
	input  wire logic           exe_fail,
	input  wire logic           mode_reject,
	input  wire logic           near_used,
	input  wire logic           addr_wr,
	input  wire logic [4:0]     addr_val,
	input  wire logic           raw_numeric_output_mode,
	input  smp_pkg::smp_resp_t  resp,
	output smp_pkg::smp_tok_t   tok,
	output logic [2:0]          depth,
	output logic                cmd_err,
	output logic                exe_err,
	output logic                dev_err,
	output logic [4:0]          bus_addr,
	output logic                resp_ready,
	output smp_pkg::smp_tx_t    tx
);
	import smp_pkg::*;

	smp_pst_t   pst, next_pst;
	smp_nst_t   nst, next_nst;
	logic [8:0] len, next_len;
	logic       common, next_common;
	smp_tok_t   next_tok;
	logic [2:0] next_depth;
	logic       next_cmd_err, next_exe_err, next_dev_err;
	logic [4:0] next_bus_addr;
	logic [Q_DEPTH-1:0][7:0] q, next_q;
	logic [2:0] qn, next_qn;
	logic       qlast, next_qlast;
	logic       pend_semi, next_pend_semi;
	logic [8:0] ocnt, next_ocnt;
	smp_tx_t    next_tx;

	// case folding of letters
	function automatic logic [7:0] fold(input logic [7:0] c);
		fold = (c >= 8'h61 && c <= 8'h7A) ? c - CASE_GAP : c;
	endfunction

	function automatic logic is_alpha(input logic [7:0] c);
		is_alpha = (c >= 8'h41 && c <= 8'h5A);
	endfunction

	function automatic logic is_digit(input logic [7:0] c);
		is_digit = (c >= 8'h30 && c <= 8'h39);
	endfunction

	// one step of the parameter syntax checker, c already folded
	function automatic smp_nst_t num_step(input smp_nst_t s, input logic [7:0] c);
		num_step = N_BAD;
		if (is_digit(c)) begin
			case (s)
				N_NONE, N_SIGN, N_INT: num_step = N_INT;
				N_FRAC: num_step = N_FRAC;
				N_EXPE, N_EXPS, N_EXPD: num_step = N_EXPD;
				N_WORD: num_step = N_WORD;
				default: num_step = N_BAD;
			endcase
		end else if (c == CH_DOT) begin
			if (s == N_NONE || s == N_SIGN || s == N_INT)
				num_step = N_FRAC;
		end else if (c == CH_PLUS || c == CH_MINUS) begin
			if (s == N_NONE)
				num_step = N_SIGN;
			else if (s == N_EXPE)
				num_step = N_EXPS;
		end else if (is_alpha(c)) begin
			case (s)
				N_INT, N_FRAC: num_step = (c == CH_E) ? N_EXPE : N_SUFX;
				N_EXPD, N_SUFX: num_step = N_SUFX;
				N_NONE, N_WORD: num_step = N_WORD;
				default: num_step = N_BAD;
			endcase
		end
	endfunction

	function automatic logic bad_end(input smp_nst_t s);
		bad_end = (s == N_SIGN || s == N_EXPE || s == N_EXPS || s == N_BAD);
	endfunction

	// ----------------------------------------
	// receive side: delimiting and path
	// ----------------------------------------
	always_comb begin
		logic [7:0] c;
		logic       term;
		logic       err;
		c = fold(rx.chr);
		term = rx.valid && (rx.chr == CH_LF || rx.eoi);
		err = 1'b0;
		next_pst = pst;
		next_nst = nst;
		next_len = len;
		next_common = common;
		next_depth = depth;
		next_tok = '0;
		next_tok.common = common;
		if (rx.valid) begin
			if (len != MSG_MAX + 9'h001)
				next_len = len + 9'h001;
			if (len == MSG_MAX && !term)
				err = 1'b1;
			if (rx.chr != CH_LF) begin
				case (pst)
					P_START, P_NODE: begin
						if (c == CH_COLON && pst == P_START) begin
							next_depth = 3'h0;
							next_tok = '{1'b1, K_ROOT, c, 1'b0, 1'b0};
							next_pst = P_NODE;
						end else if (c == CH_STAR && pst == P_START) begin
							next_common = 1'b1;
							next_tok = '{1'b1, K_MNEM, c, 1'b0, 1'b1};
							next_pst = P_MNEM;
						end else if (is_alpha(c)) begin
							next_common = 1'b0;
							next_tok = '{1'b1, K_MNEM, c, 1'b0, 1'b0};
							next_pst = P_MNEM;
						end else if (!(c <= CH_SP || (c == CH_SEMI && pst == P_START)))
							err = 1'b1;
					end
					P_MNEM: begin
						if (c == CH_COLON) begin
							if (common || !node_ok || depth == DEPTH_MAX)
								err = 1'b1;
							else begin
								next_depth = depth + 3'h1;
								next_tok = '{1'b1, K_DOWN, c, 1'b0, 1'b0};
								next_pst = P_NODE;
							end
						end else if (c == CH_SEMI) begin
							next_tok = '{1'b1, K_CEND, c, 1'b0, common};
							next_pst = P_START;
						end else if (c <= CH_SP) begin
							next_nst = N_NONE;
							next_pst = P_PARAM;
						end else if (c == CH_COMMA)
							err = 1'b1;
						else
							next_tok = '{1'b1, K_MNEM, c, 1'b0, common};
					end
					P_PARAM: begin
						if (c == CH_COMMA || c == CH_SEMI) begin
							if (bad_end(nst) || nst == N_NONE)
								err = 1'b1;
							next_tok = '{1'b1, (c == CH_COMMA) ? K_PSEP : K_CEND, c, 1'b0, common};
							next_nst = N_NONE;
							if (c == CH_SEMI)
								next_pst = P_START;
						end else if (!(c <= CH_SP && nst == N_NONE)) begin
							next_nst = num_step(nst, c);
							if (next_nst == N_BAD)
								err = 1'b1;
							next_tok = '{1'b1, K_PARAM, c, 1'b0, common};
						end
					end
					default: ;
				endcase
			end
			if (term) begin
				if (pst == P_PARAM && nst != N_NONE && bad_end(next_nst))
					err = 1'b1;
				if (!next_tok.valid)
					next_tok = '{1'b1, K_MEND, c, 1'b0, common};
				next_tok.last = 1'b1;
				next_depth = 3'h0;
				next_pst = P_START;
				next_nst = N_NONE;
				next_len = 9'h000;
				next_common = 1'b0;
			end else if (err) begin
				next_pst = P_SKIP;
				next_tok = '0;
			end
		end
		if (rx.get && len != 9'h000)
			err = 1'b1;
		next_cmd_err = err;
		next_exe_err = exe_fail || mode_reject;
		next_dev_err = near_used;
		next_bus_addr = addr_wr ? addr_val : bus_addr;
	end

	// receive registers; tokens leave in arrival order
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			pst <= P_START;
			nst <= N_NONE;
			len <= 9'h000;
			common <= 1'b0;
			depth <= 3'h0;
			tok <= '0;
			cmd_err <= 1'b0;
			exe_err <= 1'b0;
			dev_err <= 1'b0;
			bus_addr <= ADDR_RST;
		end else begin
			pst <= next_pst;
			nst <= next_nst;
			len <= next_len;
			common <= next_common;
			depth <= next_depth;
			tok <= next_tok;
			cmd_err <= next_cmd_err;
			exe_err <= next_exe_err;
			dev_err <= next_dev_err;
			bus_addr <= next_bus_addr;
		end
	end

	// ----------------------------------------
	// transmit side: response formatting
	// ----------------------------------------
	always_comb begin
		logic [7:0] c;
		c = fold(resp.chr);
		next_q = q;
		next_qn = qn;
		next_qlast = qlast;
		next_pend_semi = pend_semi;
		next_ocnt = ocnt;
		next_tx = '0;
		if (qn != 3'h0) begin
			if (ocnt < OUT_MAX || (qlast && qn == 3'h1))
				next_tx = '{1'b1, q[0], qlast && qn == 3'h1};
			if (qlast && qn == 3'h1) begin
				next_ocnt = 9'h000;
				next_qlast = 1'b0;
			end else if (ocnt != OUT_MAX)
				next_ocnt = ocnt + 9'h001;
			next_q = {8'h00, q[Q_DEPTH-1:1]};
			next_qn = qn - 3'h1;
		end else if (resp.valid && resp_ready) begin
			case (resp.kind)
				R_CHAR: begin
					if (pend_semi) begin
						next_q[next_qn[1:0]] = CH_SEMI;
						next_qn = next_qn + 3'h1;
					end
					next_pend_semi = 1'b0;
					if (resp.mult && !raw_numeric_output_mode && (c == CH_K || c == CH_M || c == CH_G)) begin
						next_q[next_qn[1:0]] = CH_E;
						next_q[next_qn[1:0] + 2'h1] = CH_PLUS;
						next_q[next_qn[1:0] + 2'h2] = (c == CH_K) ? CH_3 : (c == CH_M) ? CH_6 : CH_9;
						next_qn = next_qn + 3'h3;
					end else begin
						next_q[next_qn[1:0]] = c;
						next_qn = next_qn + 3'h1;
					end
				end
				R_ITEM: begin
					next_q[0] = CH_COMMA;
					next_qn = 3'h1;
				end
				R_UNIT: next_pend_semi = 1'b1;
				default: begin
					next_q[0] = CH_LF;
					next_qn = 3'h1;
					next_qlast = 1'b1;
					next_pend_semi = 1'b0;
				end
			endcase
		end
	end

	// transmit registers
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			q <= '0;
			qn <= 3'h0;
			qlast <= 1'b0;
			pend_semi <= 1'b0;
			ocnt <= 9'h000;
			tx <= '0;
			resp_ready <= 1'b0;
		end else begin
			q <= next_q;
			qn <= next_qn;
			qlast <= next_qlast;
			pend_semi <= next_pend_semi;
			ocnt <= next_ocnt;
			tx <= next_tx;
			resp_ready <= (next_qn == 3'h0);
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	reset_root_a: assert property (@(posedge mclk) !nrst |=> depth == 3'h0)
		else $error("path not root after reset");
	term_root_a: assert property (@(posedge mclk) disable iff (!nrst)
		rx.valid && rx.chr == CH_LF |=> depth == 3'h0 && tok.last)
		else $error("terminator did not reset path");
	fold_tok_a: assert property (@(posedge mclk) disable iff (!nrst)
		tok.valid |-> !(tok.chr >= 8'h61 && tok.chr <= 8'h7A))
		else $error("lower case token");
	semi_path_a: assert property (@(posedge mclk) disable iff (!nrst)
		rx.valid && !rx.eoi && rx.chr == CH_SEMI && pst == P_MNEM |=> $stable(depth))
		else $error("semicolon changed path");
	comma_path_a: assert property (@(posedge mclk) disable iff (!nrst)
		rx.valid && !rx.eoi && rx.chr == CH_COMMA |=> $stable(depth))
		else $error("comma changed path");
	get_err_a: assert property (@(posedge mclk) disable iff (!nrst)
		rx.get && len != 9'h000 |=> cmd_err)
		else $error("trigger in message not flagged");
	exe_err_a: assert property (@(posedge mclk) disable iff (!nrst) mode_reject |=> exe_err)
		else $error("mode rejection not flagged");
	dev_err_a: assert property (@(posedge mclk) disable iff (!nrst) near_used |=> dev_err)
		else $error("nearest value not flagged");
	tx_upper_a: assert property (@(posedge mclk) disable iff (!nrst)
		tx.valid |-> !(tx.chr >= 8'h61 && tx.chr <= 8'h7A) && (tx.eoi == (tx.chr == CH_LF)))
		else $error("bad reply character");
	addr_rst_a: assert property (@(posedge mclk) !nrst |=> bus_addr == ADDR_RST)
		else $error("bus address not default");
endmodule // smp_parser

// ---- verification/smp_host.sv ----
// Purpose: host controller model sending programs and collecting replies
// Assumes: bytes change at the falling edge of mclk
// Notes:   an idle data line shows the inverse of the last byte
`timescale 1ns/10ps
module smp_host (
	input  wire logic        mclk,
	output smp_pkg::smp_rx_t rx,
	input  smp_pkg::smp_tx_t tx
);
	import smp_pkg::*;
	logic [7:0] rep_q[$];
	logic       eoi_q[$];
	initial rx = '0;
	// one byte per cycle, back to back
	task automatic send(input logic [7:0] c, input logic e);
		@(negedge mclk);
		rx <= '{valid: 1'b1, chr: c, eoi: e, get: 1'b0};
	endtask
	// release the line, data no longer meaningful
	task automatic idle();
		@(negedge mclk);
		rx <= '{valid: 1'b0, chr: ~rx.chr, eoi: 1'b0, get: 1'b0};
	endtask
	// group trigger while the line is idle
	task automatic trig();
		@(negedge mclk);
		rx <= '{valid: 1'b0, chr: ~rx.chr, eoi: 1'b0, get: 1'b1};
		@(negedge mclk);
		rx.get <= 1'b0;
	endtask
	// whole message as given, ended by line-feed or end-or-identify
	task automatic msg(input string s, input logic eoi_end);
		for (int i = 0; i < s.len(); i++)
			send(s[i], eoi_end && i == s.len() - 1);
		if (!eoi_end)
			send(CH_LF, 1'b0);
		idle();
	endtask
	// reply capture
	always @(posedge mclk) begin
		if (tx.valid === 1'b1) begin
			rep_q.push_back(tx.chr);
			eoi_q.push_back(tx.eoi);
		end
	end
endmodule // smp_host

// ---- verification/smp_parser_tb_top.sv ----
// Purpose: self-checking bench of the message parser
// Assumes: host model drives rx; bench drives the side inputs
// Notes:   random values from a fixed seed
`timescale 1ns/10ps
module smp_parser_tb_top;
	import smp_pkg::*;
	logic mclk = 1'b0, nrst = 1'b0, node_ok = 1'b0, exe_fail = 1'b0, mode_reject = 1'b0;
	logic near_used = 1'b0, addr_wr = 1'b0, raw = 1'b0, resp_ready, cmd_err, exe_err, dev_err;
	logic [4:0] addr_val = 5'h00, bus_addr;
	logic [2:0] depth, max_dep, dep_com;
	smp_rx_t rx;
	smp_tx_t tx;
	smp_tok_t tok;
	smp_resp_t resp = '0;
	smp_kind_t tk_q[$];
	logic [7:0] tc_q[$];
	logic [2:0] dep_q[$];
	int fails = 0, num_checks = 0, n_cmd, n_exe, n_dev, seed = 58;
	string s;
	string ok_m[5] = '{":a:b 1000.0", ":a 1E+3", ":a 0.1E4", ":a 1k", ":a:b;*r"};
	string bad_m[3] = '{":a 1E", "*r:x", ":a:b"};
	always #2 mclk = ~mclk;
	smp_parser u_smp_parser (.mclk(mclk), .nrst(nrst), .rx(rx), .node_ok(node_ok), .exe_fail(exe_fail),
		.mode_reject(mode_reject), .near_used(near_used), .addr_wr(addr_wr), .addr_val(addr_val),
		.raw_numeric_output_mode(raw), .resp(resp), .tok(tok), .depth(depth), .cmd_err(cmd_err),
		.exe_err(exe_err), .dev_err(dev_err), .bus_addr(bus_addr), .resp_ready(resp_ready), .tx(tx));
	smp_host u_smp_host (.mclk(mclk), .rx(rx), .tx(tx));
	// token and error monitor
	always @(posedge mclk) begin
		if (tok.valid === 1'b1) begin
			tk_q.push_back(tok.kind);
			tc_q.push_back(tok.chr);
			if (tok.kind == K_PSEP || tok.kind == K_CEND)
				dep_q.push_back(depth);
			if (tok.common === 1'b1 && tok.kind == K_MNEM)
				dep_com = depth;
		end
		if (depth > max_dep)
			max_dep = depth;
		n_cmd += (cmd_err === 1'b1);
		n_exe += (exe_err === 1'b1);
		n_dev += (dev_err === 1'b1);
	end
	function automatic logic [7:0] up(input logic [7:0] c);
		return (c >= 8'h61 && c <= 8'h7A) ? c - CASE_GAP : c;
	endfunction
	function automatic string mexp(input logic [7:0] c, input logic r);
		if (r)
			return string'(c);
		return c == CH_K ? "E+3" : c == CH_M ? "E+6" : "E+9";
	endfunction
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic clr();
		repeat (4) @(posedge mclk);
		tk_q = {};
		tc_q = {};
		dep_q = {};
		max_dep = 3'h0;
		{n_cmd, n_exe, n_dev} = 0;
		u_smp_host.rep_q = {};
		u_smp_host.eoi_q = {};
		@(negedge mclk);
	endtask
	// one response item, held until the formatter takes it
	task automatic rsp(input smp_rkind_t k, input logic [7:0] c, input logic m);
		int n;
		@(negedge mclk);
		resp <= '{valid: 1'b1, kind: k, chr: c, mult: m};
		n = 0;
		@(posedge mclk);
		while (resp_ready !== 1'b1 && n < 50) begin
			n++;
			@(posedge mclk);
		end
		if (n == 50)
			chk("resp_ready", 1, resp_ready);
		@(negedge mclk);
		resp <= '{valid: 1'b0, kind: R_CHAR, chr: ~c, mult: 1'b0};
		repeat (2) @(posedge mclk);
		n = 0;
		while (resp_ready !== 1'b1 && n < 50) begin
			n++;
			@(posedge mclk);
		end
		if (n == 50)
			chk("resp_ready", 1, resp_ready);
	endtask
	task automatic reply_chk(input string e);
		clr();
		foreach (e[i])
			rsp(R_CHAR, e[i], 1'b0);
		rsp(R_END, CH_LF, 1'b0);
		clr();
	endtask
	task automatic pulse(input int w);
		@(negedge mclk);
		exe_fail <= (w == 0);
		mode_reject <= (w == 1);
		near_used <= (w == 2);
		@(negedge mclk);
		{exe_fail, mode_reject, near_used} <= 3'h0;
	endtask
	task automatic test_done();
		if (fails == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// hang guard, far beyond the expected run
	initial begin
		#200000;
		fails++;
		test_done();
	end
	// main sequence
	initial begin
		void'($random(seed));
		repeat (2) @(posedge mclk);
		@(negedge mclk);
		nrst <= 1'b1;
		node_ok <= 1'b1;
		@(negedge mclk);
		chk("depth", 0, depth);
		chk("bus_addr", 6, bus_addr);
		clr();
		u_smp_host.msg(":a:Bc:d 1k,2;e 3", 1'b0);
		repeat (4) @(posedge mclk);
		chk("idle tok", 0, tok.valid);
		clr();
		u_smp_host.msg(":a:Bc:d 1k,2;e 3", 1'b0);
		repeat (4) @(posedge mclk);
		chk("tok count", 15, tk_q.size());
		chk("root colon", K_ROOT, tk_q[0]);
		chk("upper", 8'h41, tc_q[1]);
		chk("max depth", 2, max_dep);
		chk("comma depth", 2, dep_q[0]);
		chk("semi depth", 2, dep_q[1]);
		chk("order", 8'h45, tc_q[12]);
		chk("end kind", K_MEND, tk_q[14]);
		chk("end depth", 0, depth);
		repeat (8) begin
			clr();
			s = ":abc d";
			for (int i = 1; i < 4; i++)
				s.putc(i, 8'h41 + ($unsigned($random(seed)) % 26) + (($random(seed) & 1) ? 8'h20 : 8'h00));
			s.putc(4, $unsigned($random(seed)) % 33);
			if (s[4] == CH_LF)
				s.putc(4, CH_SP);
			s.putc(5, 8'h30 + $unsigned($random(seed)) % 10);
			u_smp_host.msg(s, 1'b0);
			repeat (4) @(posedge mclk);
			for (int i = 1; i < 4; i++)
				chk("mnem chr", up(s[i]), tc_q[i]);
			chk("param chr", s[5], tc_q[4]);
		end
		foreach (ok_m[i]) begin
			clr();
			u_smp_host.msg(ok_m[i], i == 3);
			repeat (4) @(posedge mclk);
			chk("no error", 0, n_cmd);
		end
		chk("common depth", 1, dep_com);
		foreach (bad_m[i]) begin
			clr();
			node_ok <= (i != 2);
			u_smp_host.msg(bad_m[i], 1'b0);
			repeat (4) @(posedge mclk);
			chk("cmd error", 1, n_cmd);
			chk("depth", 0, depth);
		end
		clr();
		node_ok <= 1'b1;
		u_smp_host.send(CH_COLON, 1'b0);
		u_smp_host.trig();
		u_smp_host.msg("", 1'b0);
		repeat (4) @(posedge mclk);
		chk("trigger error", 1, n_cmd);
		clr();
		s = "";
		repeat (257) s = {s, "a"};
		u_smp_host.msg(s, 1'b0);
		repeat (4) @(posedge mclk);
		chk("length error", 1, n_cmd);
		for (int i = 0; i < 6; i++) begin
			clr();
			pulse(i % 3);
			repeat (4) @(posedge mclk);
			chk("exe err", i % 3 != 2, n_exe);
			chk("dev err", i % 3 == 2, n_dev);
		end
		@(negedge mclk);
		addr_val <= $random(seed);
		addr_wr <= 1'b1;
		@(negedge mclk);
		addr_wr <= 1'b0;
		@(negedge mclk);
		chk("bus_addr", addr_val, bus_addr);
		for (int r = 0; r < 2; r++) begin
			clr();
			raw <= r[0];
			rsp(R_CHAR, "A", 1'b0);
			rsp(R_ITEM, 8'h00, 1'b0);
			rsp(R_CHAR, "1", 1'b0);
			rsp(R_CHAR, CH_K, 1'b1);
			rsp(R_UNIT, 8'h00, 1'b0);
			rsp(R_CHAR, "B", 1'b0);
			rsp(R_END, 8'h00, 1'b0);
			repeat (4) @(posedge mclk);
			s = {"A,1", mexp(CH_K, r[0]), ";B", string'(CH_LF)};
			chk("reply len", s.len(), u_smp_host.rep_q.size());
			foreach (s[i])
				chk("reply chr", s[i], u_smp_host.rep_q[i]);
			chk("final eoi", 1, u_smp_host.eoi_q[s.len() - 1]);
			chk("early eoi", 0, u_smp_host.eoi_q[0]);
		end
		clr();
		repeat (300) rsp(R_CHAR, "X", 1'b0);
		rsp(R_END, 8'h00, 1'b0);
		repeat (4) @(posedge mclk);
		chk("long reply", 257, u_smp_host.rep_q.size());
		chk("long tail", CH_LF, u_smp_host.rep_q[256]);
		test_done();
	end
endmodule // smp_parser_tb_top
